// ---- hdl/exec_pkg.sv ----
// Shared constants and types for the block, swap and trap execution unit
package exec_pkg;
  // Register map, byte addresses on the 32-bit bus
  localparam logic [7:0]  OFS_INSTR    = 8'h00;
  localparam logic [7:0]  OFS_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_SAVED    = 8'h08;
  localparam logic [7:0]  OFS_PC       = 8'h0c;
  localparam logic [7:0]  OFS_REG_IDX  = 8'h10;
  localparam logic [7:0]  OFS_REG_DATA = 8'h14;
  localparam logic [7:0]  OFS_STAT     = 8'h18;
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_ABORT   = 1;
  // Register file: 16 visible plus banked supervisor sp/link
  localparam int          RF_AW        = 5;
  localparam logic [4:0]  PHYS_SVC_SP  = 5'h10;
  localparam logic [4:0]  PHYS_SVC_LR  = 5'h11;
  localparam logic [3:0]  IDX_SP       = 4'hd;
  localparam logic [3:0]  IDX_LR       = 4'he;
  localparam logic [3:0]  IDX_PC       = 4'hf;
  // Instruction fields
  localparam int          COND_LSB     = 28;
  localparam int          BIT_P        = 24;
  localparam int          BIT_U        = 23;
  localparam int          BIT_S        = 22;
  localparam int          BIT_B        = 22;
  localparam int          BIT_W        = 21;
  localparam int          BIT_L        = 20;
  localparam logic [2:0]  BLK_CODE     = 3'h4;
  localparam logic [3:0]  TRAP_CODE    = 4'hf;
  localparam logic [4:0]  SWP_HI       = 5'h02;
  localparam logic [7:0]  SWP_MID      = 8'h09;
  localparam logic [7:0]  RET_OPC      = 8'h1b;
  localparam logic [11:0] RET_OPND     = 12'h00e;
  // Modes, vectors, offsets, reset values
  localparam logic [4:0]  MODE_SVC     = 5'h13;
  localparam logic [4:0]  MODE_ABT     = 5'h17;
  localparam logic [31:0] TRAP_VECTOR  = 32'h0000_0008;
  localparam logic [31:0] DABT_VECTOR  = 32'h0000_0010;
  localparam logic [31:0] WORD_STEP    = 32'h0000_0004;
  localparam logic [31:0] STORE_PC_OFS = 32'h0000_000c;
  localparam logic [31:0] STATUS_RST   = 32'h0000_0013;

  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_FETCH  = 8'h02,
    S_DATA   = 8'h04,
    S_SWRD   = 8'h08,
    S_SWWR   = 8'h10,
    S_INTL   = 8'h20,
    S_REFIL1 = 8'h40,
    S_REFIL2 = 8'h80
  } state_e;
endpackage : exec_pkg

// ---- hdl/rf_if.sv ----
`timescale 1ns/1ps
// Register file access bundle between execution unit and storage
interface rf_if;
  import exec_pkg::*;
  logic [RF_AW-1:0] ra_addr;
  logic [RF_AW-1:0] rb_addr;
  logic [31:0]      rd_a;
  logic [31:0]      rd_b;
  logic             we;
  logic [RF_AW-1:0] wa;
  logic [31:0]      wd;
  modport ctrl (output ra_addr, rb_addr, we, wa, wd, input rd_a, rd_b);
  modport mem  (input ra_addr, rb_addr, we, wa, wd, output rd_a, rd_b);
endinterface : rf_if

// ---- hdl/regfile_mem.sv ----
`timescale 1ns/1ps
// Two read, one write register storage with registered read data
module regfile_mem #(
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Access bundle
  rf_if.mem        port
);
  logic [31:0] mem_q [2**AW];
  logic [31:0] rd_a_r;
  logic [31:0] rd_b_r;

  always_ff @(posedge pclk) begin
    if (port.we) begin
      mem_q[port.wa] <= port.wd;
    end
  end

  // Reads see the old word on a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_a_r <= 32'h0;
      rd_b_r <= 32'h0;
    end else begin
      rd_a_r <= mem_q[port.ra_addr];
      rd_b_r <= mem_q[port.rb_addr];
    end
  end

  assign port.rd_a = rd_a_r;
  assign port.rd_b = rd_b_r;
endmodule : regfile_mem

// ---- hdl/exec_core.sv ----
`timescale 1ns/1ps
// Execution unit for block transfers, locked swap and software trap
// How it works
// - Load-multiple abort stops register writes from the aborting load on
// - Program counter loaded last, only after all loads completed without abort
// - Aborted load-multiple restores base: original, or written-back value with write-back
// - Aborted load-multiple finishes its cycles, then enters data abort trap
// - Block: one fetch, n data, one internal; program counter load adds two fetches
// - Base written back only when write-back bit is one
// - Privilege bit: status restored with pc load, else user bank used
// - Load bit, pre/post bit and up/down bit decoded as direction and addressing
// - Stack mode names share the plain bit settings, same address sequences
// - Swap read and write are back to back and flagged locked
// - Swap reads base address, writes source, loads old value into destination
// - Byte bit selects byte swap, else word, lanes as single transfers
// - Abort on swap read or write enters data abort trap
// - Swap: one fetch, one read, one write, one internal cycle
// - Trap enters supervisor, saves status, jumps to fixed vector
// - Trap decoded from bits 27..24 all ones, comment field ignored
// - Supervisor link register gets address of following word
// - Trap takes three fetch cycles
// - Condition false makes the instruction a no-op
// - Status-setting move of link to pc returns and restores status
// - Sixteen bit list, bit k selects register k
// - Write-back lands at end of second instruction cycle
module exec_core #(
  parameter logic BIG_ENDIAN = 1'b0
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory system
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_abort,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_byte,
  output logic             mem_lock,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  // Cycle kind
  output logic             fetch_cyc,
  output logic             internal_cyc
);
  import exec_pkg::*;

  rf_if rf ();
  regfile_mem #(.AW(RF_AW)) u_rf (.pclk(pclk), .presetn(presetn), .port(rf));

  function automatic logic [3:0] lowest(input logic [15:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) r = 4'(i);
    end
    return r;
  endfunction : lowest

  function automatic logic [4:0] count(input logic [15:0] m);
    logic [4:0] r;
    r = 5'h0;
    for (int i = 0; i < 16; i++) begin
      r = r + {4'h0, m[i]};
    end
    return r;
  endfunction : count

  // Banked sp/link only when in supervisor and user bank not forced
  function automatic logic [4:0] phys(input logic [3:0] k, input logic usr, input logic [4:0] md);
    logic [4:0] r;
    r = {1'b0, k};
    if (!usr && md == MODE_SVC && k == IDX_SP) r = PHYS_SVC_SP;
    if (!usr && md == MODE_SVC && k == IDX_LR) r = PHYS_SVC_LR;
    return r;
  endfunction : phys

  function automatic logic cond_true(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    n  = f[3];
    z  = f[2];
    cy = f[1];
    v  = f[0];
    case (c)
      4'h0:    return z;
      4'h1:    return !z;
      4'h2:    return cy;
      4'h3:    return !cy;
      4'h4:    return n;
      4'h5:    return !n;
      4'h6:    return v;
      4'h7:    return !v;
      4'h8:    return cy && !z;
      4'h9:    return !cy || z;
      4'ha:    return n == v;
      4'hb:    return n != v;
      4'hc:    return !z && (n == v);
      4'hd:    return z || (n != v);
      4'he:    return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : cond_true

  state_e      state_r, state_nxt;
  logic [31:0] instr_r, status_r, saved_r, pc_r;
  logic [31:0] orig_base_r, wb_base_r, ld_data_r, pc_new_r, sw_data_r;
  logic [15:0] rd_mask_r, xfer_mask_r;
  logic [4:0]  reg_idx_r;
  logic [3:0]  ld_idx_r;
  logic        cond_ok_r, first_r, aborted_r, ld_pend_r, pc_ld_r, rb15_r, abt_flag_r, rd_wait_r;
  logic        pready_r, pslverr_r, mem_req_r, mem_we_r, mem_byte_r, mem_lock_r, fetch_r, int_r;
  logic [31:0] prdata_r, mem_addr_r, mem_wdata_r;

  // Decode of the running instruction
  logic is_blk, is_swp, is_trap, is_ret, usr_f, bit_l, bit_w, finishing, last_xfer;
  logic [3:0]  cur;
  logic [4:0]  nwords;
  logic [31:0] span, first_addr, wb_val;
  assign is_blk  = instr_r[27:25] == BLK_CODE;
  assign is_swp  = instr_r[27:23] == SWP_HI && instr_r[21:20] == 2'b00 && instr_r[11:4] == SWP_MID;
  assign is_trap = instr_r[27:24] == TRAP_CODE;
  assign is_ret  = instr_r[27:20] == RET_OPC && instr_r[15:12] == IDX_PC && instr_r[11:0] == RET_OPND;
  assign bit_l   = instr_r[BIT_L];
  assign bit_w   = instr_r[BIT_W];
  assign usr_f   = is_blk && instr_r[BIT_S] && !(bit_l && instr_r[IDX_PC]);
  assign cur     = lowest(xfer_mask_r);
  assign last_xfer = (xfer_mask_r & ~(16'h1 << cur)) == 16'h0;
  assign nwords  = count(instr_r[15:0]);
  assign span    = {25'h0, nwords, 2'b00};
  // lowest register always at lowest address
  assign first_addr = instr_r[BIT_U] ? rf.rd_a + (instr_r[BIT_P] ? WORD_STEP : 32'h0)
                                     : rf.rd_a - span + (instr_r[BIT_P] ? 32'h0 : WORD_STEP);
  assign wb_val  = instr_r[BIT_U] ? rf.rd_a + span : rf.rd_a - span;
  assign finishing = state_r != S_IDLE && state_nxt == S_IDLE;

  // Bus decode; mapped accesses wait while an instruction runs, except status reads
  logic map_hit, apb_wr, start, pw_usr;
  logic [31:0] rdval;
  assign map_hit = paddr inside {OFS_INSTR, OFS_STATUS, OFS_SAVED, OFS_PC, OFS_REG_IDX, OFS_REG_DATA, OFS_STAT};
  assign apb_wr  = psel && penable && pwrite && pready_r && !pslverr_r;
  assign start   = apb_wr && paddr == OFS_INSTR;
  assign pw_usr  = pwdata[27:25] == BLK_CODE && pwdata[BIT_S] && !(pwdata[BIT_L] && pwdata[IDX_PC]);

  always_comb begin
    case (paddr)
      OFS_INSTR:    rdval = instr_r;
      OFS_STATUS:   rdval = status_r;
      OFS_SAVED:    rdval = saved_r;
      OFS_PC:       rdval = pc_r;
      OFS_REG_IDX:  rdval = {27'h0, reg_idx_r};
      OFS_REG_DATA: rdval = rf.rd_a;
      OFS_STAT:     rdval = {30'h0, abt_flag_r, state_r != S_IDLE};
      default:      rdval = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
      rd_wait_r <= 1'b0;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      if (psel && penable && !pready_r) begin
        if (!map_hit) begin
          pready_r  <= 1'b1;
          pslverr_r <= 1'b1;
          prdata_r  <= 32'h0;
        end else if (state_r == S_IDLE || (!pwrite && paddr == OFS_STAT)) begin
          // Register file read needs one extra cycle for its registered port
          if (!pwrite && paddr == OFS_REG_DATA && !rd_wait_r) begin
            rd_wait_r <= 1'b1;
          end else begin
            rd_wait_r <= 1'b0;
            pready_r  <= 1'b1;
            prdata_r  <= pwrite ? 32'h0 : rdval;
          end
        end
      end
    end
  end

  // Register file ports
  always_comb begin
    rf.ra_addr = reg_idx_r;
    rf.rb_addr = {1'b0, lowest(rd_mask_r)};
    if (start) begin
      rf.ra_addr = (pwdata[27:20] == RET_OPC) ? phys(IDX_LR, 1'b0, status_r[4:0])
                                              : phys(pwdata[19:16], 1'b0, status_r[4:0]);
      rf.rb_addr = (pwdata[27:23] == SWP_HI) ? {1'b0, pwdata[3:0]}
                                             : phys(lowest(pwdata[15:0]), pw_usr, status_r[4:0]);
    end else if (state_r != S_IDLE) begin
      rf.rb_addr = phys(lowest(rd_mask_r), usr_f, status_r[4:0]);
    end
  end

  always_comb begin
    rf.we = 1'b0;
    rf.wa = {RF_AW{1'b0}};
    rf.wd = 32'h0;
    if (apb_wr && paddr == OFS_REG_DATA) begin
      rf.we = 1'b1;
      rf.wa = reg_idx_r;
      rf.wd = pwdata;
    end else if (state_r == S_FETCH && is_trap && cond_ok_r) begin
      rf.we = 1'b1;
      rf.wa = PHYS_SVC_LR;
      rf.wd = pc_r + WORD_STEP;
    end else if (state_r == S_DATA && first_r && bit_w) begin
      rf.we = 1'b1;
      rf.wa = phys(instr_r[19:16], 1'b0, status_r[4:0]);
      rf.wd = wb_base_r;
    end else if (ld_pend_r) begin
      rf.we = 1'b1;
      rf.wa = phys(ld_idx_r, usr_f, status_r[4:0]);
      rf.wd = ld_data_r;
    end else if (state_r == S_INTL && aborted_r && is_blk && bit_l) begin
      rf.we = 1'b1;
      rf.wa = phys(instr_r[19:16], 1'b0, status_r[4:0]);
      rf.wd = bit_w ? wb_base_r : orig_base_r;
    end else if (state_r == S_INTL && is_swp && !aborted_r) begin
      rf.we = 1'b1;
      rf.wa = phys(instr_r[15:12], 1'b0, status_r[4:0]);
      rf.wd = sw_data_r;
    end
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:   if (start) state_nxt = S_FETCH;
      S_FETCH: begin
        if (!cond_ok_r) state_nxt = S_IDLE;
        else if (is_blk) state_nxt = S_DATA;
        else if (is_swp) state_nxt = S_SWRD;
        else if (is_trap || is_ret) state_nxt = S_REFIL1;
        else state_nxt = S_IDLE;
      end
      S_DATA:   if (last_xfer) state_nxt = S_INTL;
      S_SWRD:   state_nxt = S_SWWR;
      S_SWWR:   state_nxt = S_INTL;
      // trap only after the internal cycle
      S_INTL:   state_nxt = (!aborted_r && is_blk && bit_l && instr_r[IDX_PC]) ? S_REFIL1 : S_IDLE;
      S_REFIL1: state_nxt = S_REFIL2;
      S_REFIL2: state_nxt = S_IDLE;
      default:  state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= S_IDLE;
    else state_r <= state_nxt;
  end

  // Per-instruction bookkeeping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_r     <= 32'h0;
      cond_ok_r   <= 1'b0;
      rd_mask_r   <= 16'h0;
      xfer_mask_r <= 16'h0;
      rb15_r      <= 1'b0;
      first_r     <= 1'b0;
      aborted_r   <= 1'b0;
      orig_base_r <= 32'h0;
      wb_base_r   <= 32'h0;
      ld_pend_r   <= 1'b0;
      ld_idx_r    <= 4'h0;
      ld_data_r   <= 32'h0;
      pc_ld_r     <= 1'b0;
      pc_new_r    <= 32'h0;
      sw_data_r   <= 32'h0;
    end else begin
      ld_pend_r <= 1'b0;
      if (start) begin
        instr_r     <= pwdata;
        cond_ok_r   <= cond_true(pwdata[31:28], status_r[31:28]);
        xfer_mask_r <= pwdata[15:0];
        rd_mask_r   <= pwdata[15:0] & ~(16'h1 << lowest(pwdata[15:0]));
        rb15_r      <= lowest(pwdata[15:0]) == IDX_PC;
        aborted_r   <= 1'b0;
        pc_ld_r     <= 1'b0;
      end
      if (state_r == S_FETCH || state_r == S_DATA) begin
        rd_mask_r <= rd_mask_r & ~(16'h1 << lowest(rd_mask_r));
        rb15_r    <= rd_mask_r != 16'h0 && lowest(rd_mask_r) == IDX_PC;
      end
      if (state_r == S_FETCH) begin
        orig_base_r <= rf.rd_a;
        wb_base_r   <= wb_val;
        first_r     <= 1'b1;
      end
      if (state_r == S_DATA) begin
        first_r     <= 1'b0;
        xfer_mask_r <= xfer_mask_r & ~(16'h1 << cur);
        if (mem_abort) begin
          aborted_r <= 1'b1;
        end else if (bit_l && !aborted_r) begin
          if (cur == IDX_PC) begin
            pc_ld_r  <= 1'b1;
            pc_new_r <= mem_rdata;
          end else begin
            ld_pend_r <= 1'b1;
            ld_idx_r  <= cur;
            ld_data_r <= mem_rdata;
          end
        end
      end
      if (state_r == S_SWRD || state_r == S_SWWR) begin
        if (mem_abort) aborted_r <= 1'b1;
      end
      if (state_r == S_SWRD) begin
        // byte lane follows address and endian setting
        sw_data_r <= mem_byte_r ? {24'h0, 8'(mem_rdata >> {mem_addr_r[1:0] ^ {2{BIG_ENDIAN}}, 3'b000})}
                                : mem_rdata;
      end
    end
  end

  // Memory side outputs, set for the cycle about to start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_byte_r  <= 1'b0;
      mem_lock_r  <= 1'b0;
      mem_addr_r  <= 32'h0;
      mem_wdata_r <= 32'h0;
      fetch_r     <= 1'b0;
      int_r       <= 1'b0;
    end else begin
      fetch_r    <= state_nxt inside {S_FETCH, S_REFIL1, S_REFIL2};
      int_r      <= state_nxt == S_INTL;
      mem_req_r  <= state_nxt inside {S_DATA, S_SWRD, S_SWWR};
      mem_we_r   <= (state_nxt == S_DATA && !bit_l) || state_nxt == S_SWWR;
      mem_lock_r <= state_nxt inside {S_SWRD, S_SWWR};
      mem_byte_r <= state_nxt inside {S_SWRD, S_SWWR} && instr_r[BIT_B];
      if (state_r == S_FETCH) mem_addr_r <= is_swp ? rf.rd_a : first_addr;
      else if (state_r == S_DATA) mem_addr_r <= mem_addr_r + WORD_STEP;
      if (state_r == S_FETCH && is_swp) begin
        mem_wdata_r <= instr_r[BIT_B] ? {4{rf.rd_b[7:0]}} : rf.rd_b;
      end else if (is_blk && (state_r == S_FETCH || state_r == S_DATA)) begin
        mem_wdata_r <= rb15_r ? pc_r + STORE_PC_OFS : rf.rd_b;
      end
    end
  end

  // Architectural state: pc, status, saved status, abort flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r       <= 32'h0;
      status_r   <= STATUS_RST;
      saved_r    <= 32'h0;
      reg_idx_r  <= 5'h0;
      abt_flag_r <= 1'b0;
    end else begin
      if (apb_wr) begin
        case (paddr)
          OFS_STATUS:  status_r  <= pwdata;
          OFS_SAVED:   saved_r   <= pwdata;
          OFS_PC:      pc_r      <= pwdata;
          OFS_REG_IDX: reg_idx_r <= pwdata[4:0];
          OFS_STAT:    if (pwdata[STAT_ABORT]) abt_flag_r <= 1'b0;
          default:     ;
        endcase
      end
      if (finishing) begin
        if (aborted_r) begin
          abt_flag_r     <= 1'b1;
          saved_r        <= status_r;
          status_r[4:0]  <= MODE_ABT;
          pc_r           <= DABT_VECTOR;
        end else if (cond_ok_r && is_trap) begin
          saved_r        <= status_r;
          status_r[4:0]  <= MODE_SVC;
          pc_r           <= TRAP_VECTOR;
        end else if (cond_ok_r && is_ret) begin
          pc_r           <= orig_base_r;
          status_r       <= saved_r;
        end else if (pc_ld_r) begin
          pc_r           <= pc_new_r;
          if (instr_r[BIT_S]) status_r <= saved_r;
        end else begin
          pc_r           <= pc_r + WORD_STEP;
        end
      end
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign mem_req      = mem_req_r;
  assign mem_we       = mem_we_r;
  assign mem_byte     = mem_byte_r;
  assign mem_lock     = mem_lock_r;
  assign mem_addr     = mem_addr_r;
  assign mem_wdata    = mem_wdata_r;
  assign fetch_cyc    = fetch_r;
  assign internal_cyc = int_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence swap_pair;
    mem_lock_r && !mem_we_r ##1 mem_lock_r && mem_we_r;
  endsequence
  sequence three_fetch;
    fetch_r [*3] ##1 !fetch_r;
  endsequence

  chk_swap_locked: assert property (state_r == S_FETCH && is_swp && cond_ok_r |=> swap_pair ##1 int_r)
    else $error("swap read and write not locked back to back");
  chk_swap_cycles: assert property (state_r == S_SWRD
                                    |=> state_r == S_SWWR ##1 state_r == S_INTL ##1 !mem_req_r)
    else $error("swap cycle count wrong");
  chk_trap_fetches: assert property (state_r == S_IDLE && start && pwdata[27:24] == TRAP_CODE &&
                                     cond_true(pwdata[31:28], status_r[31:28]) |=> three_fetch)
    else $error("trap did not take three fetches");
  chk_trap_vector: assert property (state_r == S_REFIL2 && is_trap && !aborted_r
                                    |=> pc_r == TRAP_VECTOR && status_r[4:0] == MODE_SVC)
    else $error("trap vector or mode wrong");
  chk_cond_skip: assert property (state_r == S_FETCH && !cond_ok_r
                                  |=> state_r == S_IDLE && !mem_req_r && !int_r)
    else $error("failed condition still executed");
  chk_no_load_after: assert property (state_r == S_DATA && (aborted_r || mem_abort) |=> !ld_pend_r)
    else $error("register written after abort");
  chk_abort_trap: assert property (state_r == S_INTL && aborted_r |=> pc_r == DABT_VECTOR && !fetch_r)
    else $error("aborted load did not trap or pc changed");
  chk_base_restore: assert property (state_r == S_INTL && aborted_r && is_blk && bit_l
                                     |-> rf.we && rf.wd == (bit_w ? wb_base_r : orig_base_r))
    else $error("base not restored after abort");
  chk_wb_second: assert property (state_r == S_DATA && first_r |-> (rf.we && rf.wd == wb_base_r) == bit_w)
    else $error("write-back missing or unrequested");
  chk_pc_refill: assert property (state_r == S_INTL && !aborted_r && is_blk && bit_l && instr_r[IDX_PC]
                                  |=> fetch_r [*2] ##1 !fetch_r && pc_r == $past(pc_new_r, 3))
    else $error("pc load did not add two fetches");
endmodule : exec_core

// ---- test/mem_model.sv ----
// Behavioural memory with a per-transfer abort
`timescale 1ns/1ps
module mem_model (
  // Clock
  input  wire logic        pclk,
  // Transfer from the core
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic        mem_byte,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  // Address that aborts, all ones for none
  input  wire logic [31:0] abort_addr,
  // Answer
  output logic      [31:0] mem_rdata,
  output logic             mem_abort
);
  logic [31:0] m [0:255];
  assign mem_abort = mem_req && mem_addr == abort_addr;
  // Inverted junk outside transfers, never a stale word
  assign mem_rdata = mem_req ? m[mem_addr[9:2]] : ~m[mem_addr[9:2]];
  // Sole bus owner, so a locked pair is never split
  always @(posedge pclk) begin
    if (mem_req && mem_we && !mem_abort && mem_byte) m[mem_addr[9:2]][8 * mem_addr[1:0] +: 8] <= mem_wdata[7:0];
    else if (mem_req && mem_we && !mem_abort) m[mem_addr[9:2]] <= mem_wdata;
  end
endmodule : mem_model

// ---- test/exec_core_tb.sv ----
// Self-checking bench for the block, swap and trap unit
`timescale 1ns/1ps
module exec_core_tb;
  import exec_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic pready, pslverr, mem_abort, mem_req, mem_we, mem_byte, mem_lock, fetch_cyc, internal_cyc;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 0, abort_addr = 32'hffff_ffff, prdata, mem_rdata, mem_addr, mem_wdata, q, b, s, v, d, t0;
  logic [31:0] tally = 0;
  logic [31:0] vals [0:11];
  int n_errors = 0, n_tests = 0, cyc = 0, n;
  exec_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .mem_rdata, .mem_abort, .mem_req, .mem_we, .mem_byte, .mem_lock, .mem_addr, .mem_wdata, .fetch_cyc, .internal_cyc);
  mem_model mem_u (.pclk, .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .abort_addr, .mem_rdata, .mem_abort);
  always #50 pclk = ~pclk;
  // Packed tally, one byte each for locked, fetch, data and internal cycles
  always @(posedge pclk) begin
    tally <= tally + {7'h0, mem_lock === 1'b1, 7'h0, fetch_cyc === 1'b1,
                      7'h0, mem_req === 1'b1, 7'h0, internal_cyc === 1'b1};
    if (++cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // Lowest transfer address; mode bit 0 is up/down, bit 1 is pre/post
  function automatic logic [31:0] low_addr(input logic [31:0] base, input int mode, input int words);
    return mode[0] ? base + (mode[1] ? 32'h4 : 32'h0) : base - 4 * words + (mode[1] ? 32'h0 : 32'h4);
  endfunction : low_addr
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {q, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  task rf(input logic w, input int i, input logic [31:0] wd);
    apb(1, OFS_REG_IDX, i);
    apb(w, OFS_REG_DATA, wd);
  endtask : rf
  // Polls the status word, which answers even while busy
  task run(input logic [31:0] ins);
    apb(1, OFS_INSTR, ins);
    t0 = tally;
    do apb(0, OFS_STAT, 0); while (q[STAT_BUSY] === 1'b1);
    t0 = tally - t0;
  endtask : run
  task report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  initial begin
    v = $urandom(7);
    for (int i = 0; i < 256; i++) mem_u.m[i] = $urandom;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h1c, 0);
    chk("unmapped err", 1, err);
    s = {4'($urandom), 23'h0, 5'h10};
    apb(1, OFS_STATUS, s);
    apb(0, OFS_PC, 0);
    b = q;
    run({4'he, TRAP_CODE, 24'($urandom)});
    chk("trap cycles", 32'h030000, t0);
    apb(0, OFS_PC, 0);
    chk("trap pc", TRAP_VECTOR, q);
    apb(0, OFS_SAVED, 0);
    chk("saved status", s, q);
    apb(0, OFS_STATUS, 0);
    chk("trap mode", MODE_SVC, q[4:0]);
    rf(0, PHYS_SVC_LR, 0);
    chk("link", b + 32'h4, q);
    run(32'he1b0f00e);
    apb(0, OFS_PC, 0);
    chk("return pc", b + 32'h4, q);
    apb(0, OFS_STATUS, 0);
    chk("return status", s, q);
    run({4'hf, TRAP_CODE, 24'h0});
    chk("never cycles", 32'h010000, t0);
    for (int k = 0; k < 2; k++) begin
      b = 32'h100 + k * ($urandom % 4);
      v = $urandom;
      rf(1, 2, b);
      rf(1, 1, v);
      s = mem_u.m[b[9:2]];
      d = k ? s >> (8 * b[1:0]) & 32'hff : s;
      run(32'he1020091 | (k << 22));
      chk("swap cycles", 32'h02010201, t0);
      rf(0, 0, 0);
      chk("swap dest", d, q);
      if (k) s[8 * b[1:0] +: 8] = v[7:0];
      else s = v;
      chk("swap mem", s, mem_u.m[b[9:2]]);
    end
    for (int k = 0; k < 4; k++) begin
      b = 32'h200;
      rf(1, 12, b);
      for (int r = 0; r < 12; r++) begin
        vals[r] = $urandom;
        rf(1, r, vals[r]);
      end
      d = $urandom & 32'h0fff | 32'h1;
      v = $urandom;
      n = $countones(d[15:0]);
      run({4'he, 3'h4, 2'(k), 1'b0, v[0], 1'b0, 4'hc, d[15:0]});
      s = low_addr(b, k, n);
      for (int r = 0; r < 12; r++) if (d[r]) begin
        chk("store word", vals[r], mem_u.m[s[9:2]]);
        s += 4;
      end
      rf(0, 12, 0);
      chk("base", v[0] ? (k[0] ? b + 4 * n : b - 4 * n) : b, q);
      chk("store cycles", 32'h010001 | n << 8, t0);
    end
    b = 32'h300;
    rf(1, 12, b);
    mem_u.m[b[9:2] + 1] = 32'h340;
    apb(1, OFS_SAVED, 32'h6000_0013);
    run(32'he8dc8001);
    chk("ldm pc cycles", 32'h030201, t0);
    rf(0, 0, 0);
    chk("ldm r0", mem_u.m[b[9:2]], q);
    apb(0, OFS_PC, 0);
    chk("ldm pc", 32'h340, q);
    apb(0, OFS_STATUS, 0);
    chk("ldm status", 32'h6000_0013, q);
    rf(1, 12, b);
    rf(1, 1, 32'h11);
    rf(1, 3, 32'h33);
    abort_addr <= b + 32'h4;
    run(32'he8bc900b);
    abort_addr <= 32'hffff_ffff;
    chk("abort cycles", 32'h010501, t0);
    rf(0, 1, 0);
    chk("abort r1", 32'h11, q);
    rf(0, 3, 0);
    chk("abort r3", 32'h33, q);
    rf(0, 12, 0);
    chk("abort base", b + 32'h14, q);
    apb(0, OFS_PC, 0);
    chk("abort pc", DABT_VECTOR, q);
    apb(0, OFS_STAT, 0);
    chk("abort flag", 32'h2, q);
    // Swap whose address aborts: flag cleared first so it must be set again
    apb(1, OFS_STAT, 32'h2);
    apb(1, OFS_PC, 32'h0);
    rf(1, 2, b);
    rf(1, 0, 32'h5a);
    abort_addr <= b;
    run(32'he1020091);
    abort_addr <= 32'hffff_ffff;
    chk("swap abort cycles", 32'h02010201, t0);
    rf(0, 0, 0);
    chk("swap abort dest", 32'h5a, q);
    apb(0, OFS_PC, 0);
    chk("swap abort pc", DABT_VECTOR, q);
    apb(0, OFS_STAT, 0);
    chk("swap abort flag", 32'h2, q);
    report_and_stop();
  end
endmodule : exec_core_tb
